// [aic_inject_ctrl.v]
// aic_inject_ctrl.v: channel injection control for the converter
// assumes the analog front end samples o_CONV_CH while o_CONV_BUSY is high
// and returns its value on I_CONV_DATA at the end of the conversion
`timescale 1ns/1ps
`default_nettype none
`include "aic_regs.vh"

// Function
// R01: software enables wait-for-read before injecting
// R02: injection converts one channel, mode kept
// R03: done: result register loaded, flag, irq
// R04: full holding register suspends next conversion
// R05: extra injection result waits in holding
// R06: injection result read refills and re-interrupts
// R07: capture/compare channel 31 may trigger
// R08: toggling wait-for-read resumes stalled converter
// R09: reader should read injection result twice
// R10: software must avoid two injections unread
// R11: flag sticky, set wins over clear
module aic_inject_ctrl #(
    parameter integer RES_W    = `AIC_RES_W,    // result width
    parameter integer CH_W     = `AIC_CH_W,     // channel field width
    parameter integer CONV_CYC = `AIC_CONV_CYC  // cycles per conversion
) (
    // clock and reset
    input  wire             I_MCLK,
    input  wire             I_NRST,
    // mode control
    input  wire             I_WAIT_READ_EN,      // wait-for-result-read mode
    input  wire             I_STD_RUN,           // standard mode requests
    input  wire [CH_W-1:0]  I_STD_CH,            // standard channel
    // injection requests
    input  wire             I_INJ_SW_REQ,        // software request pulse
    input  wire             I_INJECTION_TRIGGER_CHANNEL, // cap/cmp ch 31
    input  wire [CH_W-1:0]  I_INJ_CH,            // injected channel
    // reader side
    input  wire             I_STD_RD,            // standard result read
    input  wire             I_INJ_RD,            // injection result read
    input  wire             I_FLAG_CLR,          // software or acknowledge
    // analog front end
    input  wire [RES_W-1:0] I_CONV_DATA,
    output wire             o_CONV_BUSY,
    output reg  [CH_W-1:0]  o_CONV_CH,
    // results
    output reg  [RES_W-1:0] o_STANDARD_RESULT_REG,
    output reg  [RES_W-1:0] o_INJECTION_RESULT_REG,
    output reg              o_INJECTION_DONE_FLAG,
    output reg              o_INJECTION_DONE_IRQ,
    output reg              o_HOLD_FULL
);
    // conversion engine states, one-hot; each decode still compares all three bits
    // idle: waiting for a request and a free holding register
    // conv: the front end converts the channel on o_CONV_CH
    // done: one cycle in which the front end data is stored
    localparam [2:0] SQ_IDLE = 3'b001;
    localparam [2:0] SQ_CONV = 3'b010;
    localparam [2:0] SQ_DONE = 3'b100;

    reg  [2:0]       state_q;            // engine state
    reg              cur_inj_q;          // current conversion is injected
    reg              inj_pend_q;         // injection request latched
    reg  [CH_W-1:0]  inj_ch_q;           // latched injected channel
    reg              std_full_q;         // standard result unread
    reg              inj_full_q;         // injection result unread
    reg  [RES_W-1:0] hold_q;             // temporary holding register
    reg              hold_inj_q;         // holding register owns injection
    reg              wait_q;             // previous wait-mode level
    reg              res_done_q;         // sample point of conversion end
    wire             tmr_done;
    wire             inj_req;
    wire             start;
    wire             wait_fall;

    // hardware trigger from the capture/compare unit or software
    assign inj_req   = I_INJ_SW_REQ | I_INJECTION_TRIGGER_CHANNEL; // R07
    // leaving wait mode frees a stalled converter
    assign wait_fall = wait_q & ~I_WAIT_READ_EN;                   // R08

    // start only while the holding register is free; a pending
    // injection wins over the standard mode, which simply resumes later
    assign start = (state_q == SQ_IDLE) && !o_HOLD_FULL &&         // R04
                   (inj_pend_q || I_STD_RUN);
    // busy is decoded from the state so the front end sees it at once
    assign o_CONV_BUSY = (state_q == SQ_CONV);

    // counts the conversion time
    aic_conv_timer #(
        .CYC    (CONV_CYC)
    ) u_tmr (
        .i_clk  (I_MCLK),
        .i_nrst (I_NRST),
        .i_start(start),
        .o_busy (),
        .o_done (tmr_done)
    );

    // latch injection requests; one outstanding request is remembered
    // a request arriving while one is pending overwrites the channel,
    // so software must not stack requests faster than results are read
    always @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            inj_pend_q <= 1'b0;
            inj_ch_q   <= `AIC_CH_RST;
            wait_q     <= 1'b0;
        end else begin
            wait_q <= I_WAIT_READ_EN;
            if (inj_req) begin
                inj_pend_q <= 1'b1;
                inj_ch_q   <= I_INJ_CH;
            end else if (start && inj_pend_q) begin
                inj_pend_q <= 1'b0;  // injection takes priority
            end
        end
    end

    // conversion sequencer; injection never alters the standard mode
    // the standard channel is sampled afresh at each start, so an
    // injection in between leaves the scan sequence untouched
    always @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_q    <= SQ_IDLE;
            cur_inj_q  <= 1'b0;
            o_CONV_CH  <= `AIC_CH_RST;
            res_done_q <= 1'b0;
        end else begin
            res_done_q <= 1'b0;
            case (state_q)
                SQ_IDLE: begin
                    if (start) begin
                        state_q   <= SQ_CONV;
                        cur_inj_q <= inj_pend_q;                   // R02
                        o_CONV_CH <= inj_pend_q ? inj_ch_q : I_STD_CH;
                    end
                end
                SQ_CONV: begin
                    // the timer shares the start pulse, so both end together
                    if (tmr_done) begin
                        state_q    <= SQ_DONE;
                        res_done_q <= 1'b1;
                    end
                end
                SQ_DONE: begin
                    state_q <= SQ_IDLE;  // one cycle to store result
                end
                default: begin
                    state_q <= SQ_IDLE;  // illegal code, recover to idle
                end
            endcase
        end
    end

    // result storage, holding register and interrupt generation
    // the holding register is shared by both result kinds; hold_inj_q
    // records whose value it carries so only the matching read, or leaving wait mode, frees it
    always @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            o_STANDARD_RESULT_REG  <= `AIC_RES_RST;
            o_INJECTION_RESULT_REG <= `AIC_RES_RST;
            hold_q                 <= `AIC_RES_RST;
            hold_inj_q             <= 1'b0;
            o_HOLD_FULL            <= 1'b0;
            std_full_q             <= 1'b0;
            inj_full_q             <= 1'b0;
            o_INJECTION_DONE_IRQ   <= 1'b0;
        end else begin
            o_INJECTION_DONE_IRQ <= 1'b0;
            // reads empty the result registers
            if (I_STD_RD) begin
                std_full_q <= 1'b0;
            end
            if (I_INJ_RD) begin
                inj_full_q <= 1'b0;
            end
            // read of injection result refills from holding and interrupts
            if (I_INJ_RD && o_HOLD_FULL && hold_inj_q) begin
                o_INJECTION_RESULT_REG <= hold_q;                  // R06
                inj_full_q             <= 1'b1;
                o_HOLD_FULL            <= 1'b0;
                o_INJECTION_DONE_IRQ   <= 1'b1;                    // R06
            end else if (I_STD_RD && o_HOLD_FULL && !hold_inj_q) begin
                o_STANDARD_RESULT_REG <= hold_q;
                std_full_q            <= 1'b1;
                o_HOLD_FULL           <= 1'b0;
            end else if (wait_fall) begin
                o_HOLD_FULL <= 1'b0;  // recovery drops the held value
            end
            // new result: to result register or into holding register
            if (res_done_q) begin
                if (cur_inj_q) begin
                    if (inj_full_q && !I_INJ_RD && I_WAIT_READ_EN) begin
                        hold_q      <= I_CONV_DATA;                // R05
                        hold_inj_q  <= 1'b1;
                        o_HOLD_FULL <= 1'b1;                       // R04
                    end else begin
                        o_INJECTION_RESULT_REG <= I_CONV_DATA;     // R03
                        inj_full_q             <= 1'b1;
                        o_INJECTION_DONE_IRQ   <= 1'b1;            // R03
                    end
                end else begin
                    if (std_full_q && !I_STD_RD && I_WAIT_READ_EN) begin
                        hold_q      <= I_CONV_DATA;                // R04
                        hold_inj_q  <= 1'b0;
                        o_HOLD_FULL <= 1'b1;
                    end else begin
                        o_STANDARD_RESULT_REG <= I_CONV_DATA;
                        std_full_q            <= 1'b1;
                    end
                end
            end
        end
    end

    // sticky completion flag: a new completion beats a clear
    // a clear that meets a completion is dropped on purpose, so the
    // reader never loses track of a freshly stored result
    always @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            o_INJECTION_DONE_FLAG <= 1'b0;
        end else if (o_INJECTION_DONE_IRQ) begin
            o_INJECTION_DONE_FLAG <= 1'b1;                         // R11
        end else if (I_FLAG_CLR) begin
            o_INJECTION_DONE_FLAG <= 1'b0;                         // R11
        end
    end
endmodule

`default_nettype wire

// [aic_regs.vh]
// aic_regs.vh: constants for the injection control block
// assumes inclusion by bare name from the design files
`ifndef AIC_REGS_VH
`define AIC_REGS_VH

// width of one conversion result
`define AIC_RES_W        10
// conversion time in ns and derived cycle count at 10 ns per cycle
`define AIC_CONV_NS      3000
`define AIC_CLK_NS       10
`define AIC_CONV_CYC     ((`AIC_CONV_NS + `AIC_CLK_NS - 1) / `AIC_CLK_NS)
// reset values
`define AIC_RES_RST      10'h000
`define AIC_CH_RST       5'h00
// channel field width
`define AIC_CH_W         5

`endif

// [aic_conv_timer.v]
// aic_conv_timer.v: conversion duration counter
// assumes a single clock; start is ignored while busy
`timescale 1ns/1ps
`default_nettype none

module aic_conv_timer #(
    parameter integer CYC = 300     // cycles per conversion
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_nrst,
    // control
    input  wire        i_start,
    output reg         o_busy,
    output wire        o_done
);
    localparam integer CW = 16;
    reg [CW-1:0] cnt_q;              // remaining cycles

    // single-cycle done when the count expires
    assign o_done = o_busy && (cnt_q == {{(CW-1){1'b0}}, 1'b1});

    // load on start, count down while busy
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q  <= 16'h0000;
            o_busy <= 1'b0;
        end else if (o_busy) begin
            cnt_q  <= cnt_q - 16'h0001;
            if (o_done) begin
                o_busy <= 1'b0;      // conversion finished
            end
        end else if (i_start) begin
            cnt_q  <= CYC[CW-1:0];
            o_busy <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// [aic_inject_sva.sv]
// aic_inject_sva.sv: port checker for the injection controller
// assumes the bench builds the design with CONV_CYC of 4
`timescale 1ns/1ps
`default_nettype none
module aic_inject_sva #(
    parameter integer RES_W    = 10,
    parameter integer CH_W     = 5,
    parameter integer CONV_CYC = 4
) (
    // watched ports
    input wire logic            I_MCLK,
    input wire logic            I_NRST,
    input wire logic            I_WAIT_READ_EN,
    input wire logic            I_FLAG_CLR,
    input wire logic            o_CONV_BUSY,
    input wire logic [CH_W-1:0] o_CONV_CH,
    input wire logic            o_INJECTION_DONE_FLAG,
    input wire logic            o_INJECTION_DONE_IRQ,
    input wire logic            o_HOLD_FULL
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    // repetition count is literal: it must track CONV_CYC
    sequence s_conv;
        o_CONV_BUSY [*4] ##1 !o_CONV_BUSY;
    endsequence
    chk_conv_len: assert property ($rose(o_CONV_BUSY) |-> s_conv)
        else $error("conversion length wrong");
    chk_ch_steady: assert property (
        o_CONV_BUSY && $past(o_CONV_BUSY) |-> $stable(o_CONV_CH))
        else $error("channel moved mid conversion");
    chk_irq_pulse: assert property (o_INJECTION_DONE_IRQ |=>
        !o_INJECTION_DONE_IRQ) else $error("irq longer than a cycle");
    chk_irq_flag: assert property (o_INJECTION_DONE_IRQ |=>
        o_INJECTION_DONE_FLAG) else $error("flag not set by done");
    chk_flag_keep: assert property (
        o_INJECTION_DONE_FLAG && !I_FLAG_CLR |=> o_INJECTION_DONE_FLAG)
        else $error("flag dropped without clear");
    chk_flag_clear: assert property (
        I_FLAG_CLR && !o_INJECTION_DONE_IRQ |=> !o_INJECTION_DONE_FLAG)
        else $error("flag not cleared");
    chk_full_stall: assert property (
        $rose(o_CONV_BUSY) |-> !$past(o_HOLD_FULL))
        else $error("conversion started while holding full");
    chk_wait_drop: assert property (
        $fell(I_WAIT_READ_EN) |-> ##[1:2] !o_HOLD_FULL)
        else $error("holding not released by mode drop");
    chk_full_mode: assert property (o_HOLD_FULL |-> I_WAIT_READ_EN ||
        $past(I_WAIT_READ_EN) || $past(I_WAIT_READ_EN, 2))
        else $error("holding used outside wait mode");
endmodule
bind aic_inject_ctrl aic_inject_sva #(.RES_W(RES_W), .CH_W(CH_W),
    .CONV_CYC(CONV_CYC)) u_sva (.*);
`default_nettype wire

// [aic_afe_model.sv]
// aic_afe_model.sv: analog front end, returns a code per channel
// assumes data is sampled within three cycles after busy falls
`timescale 1ns/1ps
`default_nettype none
module aic_afe_model (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic [4:0] ch,
    output logic      [9:0] data
);
    logic [4:0] ch_q;   // channel being converted
    logic [1:0] hold_q; // cycles left that data stays valid
    // capture channel during conversion, then count hold time down
    always @(posedge clk) begin
        if (busy) begin
            ch_q   <= ch;
            hold_q <= 2'h3;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end
    // outside the hold time the value is inverted so stale data shows
    assign data = (busy || hold_q != 2'h0) ? {ch_q, ~ch_q} : {~ch_q, ch_q};
endmodule
`default_nettype wire

// [tb.sv]
// tb.sv: self-checking bench for the injection controller
// assumes aic_afe_model stands in for the analog front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, a, b); end end
module tb;
    logic mclk = 0, nrst = 0, wen = 0, srun = 0, sreq = 0, trg = 0;
    logic ird = 0, srd = 0, clr = 0, busy, flg, irq, full;
    logic [4:0] sch = 5'h00, ich = 5'h00, cch;
    logic [9:0] cdat, sres, ires;
    int n_mismatch = 0, total_checks = 0;
    always #5 mclk = ~mclk;
    aic_afe_model u_afe (.clk(mclk), .busy(busy), .ch(cch), .data(cdat));
    aic_inject_ctrl #(.CONV_CYC(4)) dut (.I_MCLK(mclk), .I_NRST(nrst),
        .I_WAIT_READ_EN(wen), .I_STD_RUN(srun), .I_STD_CH(sch),
        .I_INJ_SW_REQ(sreq), .I_INJECTION_TRIGGER_CHANNEL(trg),
        .I_INJ_CH(ich), .I_STD_RD(srd), .I_INJ_RD(ird),
        .I_FLAG_CLR(clr), .I_CONV_DATA(cdat), .o_CONV_BUSY(busy),
        .o_CONV_CH(cch), .o_STANDARD_RESULT_REG(sres),
        .o_INJECTION_RESULT_REG(ires), .o_INJECTION_DONE_FLAG(flg),
        .o_INJECTION_DONE_IRQ(irq), .o_HOLD_FULL(full));
    function automatic logic [9:0] fx(input logic [4:0] c);
        return {c, ~c};
    endfunction
    // request pulse, from software or from the compare trigger
    task inj(input logic t, input logic [4:0] c);
        @(posedge mclk) begin
            ich <= c;
            if (t) trg <= 1'b1; else sreq <= 1'b1;
        end
        @(posedge mclk) begin
            sreq <= 1'b0;
            trg  <= 1'b0;
        end
    endtask
    task rd;
        @(posedge mclk) ird <= 1'b1;
        @(posedge mclk) ird <= 1'b0;
    endtask
    // standard result read pulse
    task srd_p;
        @(posedge mclk) srd <= 1'b1;
        @(posedge mclk) srd <= 1'b0;
    endtask
    // bounded wait; result is judged in the irq cycle itself
    task wirq(input logic [9:0] e);
        @(negedge mclk);
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge mclk);
        `CHK(irq, 1'b1)
        `CHK(ires, e)
        @(negedge mclk) `CHK(flg, 1'b1)
    endtask
    task t_basic(input logic t, input logic [4:0] c);
        inj(t, c);
        repeat (2) @(negedge mclk);
        `CHK(busy, 1'b1)
        `CHK(cch, c)
        wirq(fx(c));
        rd;
        rd;
        @(posedge mclk) clr <= 1'b1;
        @(posedge mclk) clr <= 1'b0;
        @(negedge mclk) `CHK(flg, 1'b0)
    endtask
    task t_hold;
        inj(0, 5'h05);
        wirq(fx(5'h05));
        inj(0, 5'h0a);
        repeat (20) @(negedge mclk);
        `CHK(full, 1'b1)
        `CHK(ires, fx(5'h05))
        inj(0, 5'h0c);
        repeat (10) @(negedge mclk) `CHK(busy, 1'b0)
        rd;
        wirq(fx(5'h0a));
        repeat (20) @(negedge mclk);
        `CHK(full, 1'b1)
        @(posedge mclk) wen <= 1'b0;
        @(posedge mclk) wen <= 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(full, 1'b0)
        rd;
        inj(0, 5'h06);
        wirq(fx(5'h06));
        rd;
    endtask
    task t_std;
        @(posedge mclk) begin
            wen  <= 1'b0;
            sch  <= 5'h07;
            srun <= 1'b1;
        end
        inj(0, 5'h12);
        wirq(fx(5'h12));
        @(posedge mclk) srun <= 1'b0;
        repeat (20) @(negedge mclk);
        `CHK(sres, fx(5'h07))
    endtask
    // standard results parked in the holding register in wait mode
    task t_shold;
        @(posedge mclk) begin
            wen  <= 1'b1;
            sch  <= 5'h09;
            srun <= 1'b1;
        end
        repeat (20) @(negedge mclk);
        `CHK(full, 1'b1)
        `CHK(sres, fx(5'h07))
        repeat (5) @(negedge mclk) `CHK(busy, 1'b0)
        @(posedge mclk) sch <= 5'h0b;
        srd_p;
        repeat (2) @(negedge mclk);
        `CHK(sres, fx(5'h09))
        repeat (20) @(negedge mclk);
        `CHK(full, 1'b1)
        `CHK(sres, fx(5'h09))
        @(posedge mclk) srun <= 1'b0;
        srd_p;
        @(negedge mclk) `CHK(irq, 1'b0)
        repeat (19) @(negedge mclk);
        `CHK(full, 1'b0)
        `CHK(sres, fx(5'h0b))
    endtask
    task test_done;
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #50us;
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        wen  <= 1'b1;
        t_basic(0, 5'h03);
        t_basic(1, 5'h1f);
        t_hold;
        t_std;
        t_shold;
        test_done;
    end
endmodule
`default_nettype wire
